// file: dv/fpec_cpu.sv
// fpec_cpu.sv: cpu model issuing external-move writes.
// assumes: go from the bench; same clock as the block.
`timescale 1ns/1ps
module fpec_cpu (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [15:0] a,
  input wire logic [7:0] d,
  input wire logic sh,
  input wire logic cpu_stall,
  output logic xw_valid,
  output logic [15:0] xw_addr,
  output logic [7:0] xw_data,
  output logic xw_short
);
  // released address and data lines invert so stale values never look live
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xw_valid <= 1'b0;
      xw_addr <= 16'h0;
      xw_data <= 8'h0;
      xw_short <= 1'b0;
    end else if (xw_valid && !cpu_stall) begin
      xw_valid <= 1'b0;
      xw_addr <= ~xw_addr;
      xw_data <= ~xw_data;
    end else if (go && !xw_valid) begin
      xw_valid <= 1'b1;
      xw_addr <= a;
      xw_data <= d;
      xw_short <= sh;
    end
  end
endmodule

// file: dv/fpec_monitor.sv
// fpec_monitor.sv: port assertions for fpec_top.
// assumes: bound to fpec_top, one clock, reset low.
`timescale 1ns/1ps
module fpec_monitor #(
  parameter int PROG_CYC = 4,
  parameter int ERASE_CYC = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic xw_valid,
  input wire logic [15:0] xw_addr,
  input wire logic xw_short,
  input wire logic xram_we,
  input wire logic [15:0] xram_addr,
  input wire logic cpu_stall,
  input wire logic supply_mon_en,
  input wire logic supply_mon_rst_src,
  input wire logic flash_err_rst
);
  int n;
  wire ok = supply_mon_en && supply_mon_rst_src;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) n <= 0;
    else n <= !cpu_stall ? 0 : ce ? n + 1 : n;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_stall_len: assert property ($fell(cpu_stall) |->
    n == PROG_CYC || n == ERASE_CYC) else $error("stall length");
  a_stall_ends: assert property (cpu_stall && ce |-> n < ERASE_CYC)
    else $error("stall stuck");
  a_op_supply: assert property ($rose(cpu_stall) && $past(xw_valid) |->
    $past(ok)) else $error("op with monitor off");
  a_err_cause: assert property (flash_err_rst |->
    $past(xw_valid) && !$past(ok)) else $error("error reset uncaused");
  a_err_pulse: assert property (flash_err_rst |=>
    !flash_err_rst && !cpu_stall) else $error("error reset pulse");
  a_short_cap: assert property (xw_valid && xw_short && !cpu_stall &&
    xw_addr > 16'h00ff |=> !cpu_stall) else $error("short write op");
  a_xram_copy: assert property (xram_we |->
    $past(xw_valid) && xram_addr == $past(xw_addr)) else $error("xram");
  a_xram_excl: assert property (xram_we |->
    !cpu_stall && !flash_err_rst) else $error("xram during op");
endmodule

bind fpec_top fpec_monitor #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC))
  u_mon (.hclk, .hresetn, .ce, .xw_valid, .xw_addr, .xw_short, .xram_we,
  .xram_addr, .cpu_stall, .supply_mon_en, .supply_mon_rst_src,
  .flash_err_rst);

// file: dv/tb.sv
// tb.sv: self-checking bench for fpec_top, small flash.
// assumes: fpec_cpu issues writes; 16-byte pages.
`timescale 1ns/1ps
module tb;
  localparam int EC = 20;
  logic hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0, go = 1'b0;
  logic sh = 1'b0, strap = 1'b0, dbg_we = 1'b0, hwrite = 1'b0;
  logic ce = 1'b1, dbg_erase = 1'b1, hresp;
  logic sup_en = 1'b1, sup_rs = 1'b1;
  logic rd_v = 1'b0, rd_d = 1'b0, hrd_d = 1'b0, hreadyout, ferr;
  logic xw_valid, xw_short, xram_we, cpu_stall;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lfsr = 32'h20;
  logic [15:0] a = 16'h0, xw_addr, xram_addr;
  logic [7:0] d = 8'h0, r1, xw_data, xram_data, fetch_data;
  logic [5:0] fetch_addr = 6'h0;
  logic [5:0] dbg_addr = 6'h0;
  logic [7:0] dbg_data = 8'hff;
  logic [31:0] q[$];
  int err_total = 0, cmp_count = 0;
  fpec_top #(.PAGE_BYTES(16), .NUM_PAGES(4), .PROG_CYC(4), .ERASE_CYC(EC))
    dut (.hclk, .hresetn, .por_n, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .xw_valid, .xw_addr, .xw_data, .xw_short, .xram_we,
    .xram_addr, .xram_data, .cpu_stall, .fetch_addr, .fetch_data,
    .supply_mon_en(sup_en), .supply_mon_rst_src(sup_rs),
    .init_strap(strap), .dbg_we, .dbg_erase, .dbg_addr,
    .dbg_data, .flash_err_rst(ferr));
  fpec_cpu cpu (.hclk, .hresetn, .go, .a, .d, .sh, .cpu_stall, .xw_valid,
    .xw_addr, .xw_data, .xw_short);
  initial forever #12.5 hclk = ~hclk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task summarize;
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] v);
    logic [31:0] e;
    e = q.pop_front();
    cmp_count++;
    if (v !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, v);
    end
  endtask
  always @(posedge hclk) begin
    if (rd_d) chk("flash", {24'h0, fetch_data});
    if (hrd_d) chk("reg", hrdata);
    if (xram_we) chk("xram", {xram_addr, 8'h0, xram_data});
    if (ferr) chk("err_rst", {31'h0, ferr});
    if (hrd_d && hresp !== 1'b0) begin
      err_total++;
      $display("CHECK FAILED hresp exp 0 got %b", hresp);
    end
    rd_d <= rd_v;
    hrd_d <= hsel && htrans[1] && !hwrite;
  end
  task wt(input logic stall);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((stall ? cpu_stall : !hreadyout) !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_total++;
      summarize();
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] v);
    if (!w) q.push_back(v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    wt(1'b0);
    htrans <= 2'h0;
    hwdata <= v;
    wt(1'b0);
  endtask
  task dbg(input logic e, input logic [5:0] ad, input logic [7:0] v,
    input int hold);
    dbg_erase <= e;
    dbg_addr <= ad;
    dbg_data <= v;
    dbg_we <= 1'b1;
    @(posedge hclk);
    dbg_we <= 1'b0;
    if (hold > 0) begin
      ce <= 1'b0;
      repeat (hold) @(posedge hclk);
      q.push_back(32'h1);
      chk("freeze", {31'h0, cpu_stall});
      ce <= 1'b1;
    end
    @(posedge hclk);
    wt(1'b1);
  endtask
  task unlock;
    bus(1'b1, 8'h4, 32'ha5);
    bus(1'b1, 8'h4, 32'hf1);
  endtask
  task xw(input logic [15:0] ad, input logic [7:0] v, input logic s);
    a <= ad;
    d <= v;
    sh <= s;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    wt(1'b1);
  endtask
  task fl(input logic [5:0] ad, input logic [7:0] e);
    q.push_back({24'h0, e});
    fetch_addr <= ad;
    rd_v <= 1'b1;
    @(posedge hclk);
    rd_v <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task rst;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  initial begin
    rst();
    dbg(1'b1, 6'h0, 8'hff, 0);
    dbg(1'b0, 6'h7, 8'h3c, 6);
    fl(6'h7, 8'h3c);
    bus(1'b1, 8'h0, 32'h1);
    unlock();
    xw(16'h3, 8'h5a, 1'b0);
    fl(6'h3, 8'hff);
    strap <= 1'b1;
    rst();
    lfsr = nxt(lfsr);
    r1 = lfsr[7:0];
    bus(1'b1, 8'h0, 32'h1);
    unlock();
    bus(1'b0, 8'h4, 32'h4);
    xw(16'h3, r1, 1'b0);
    fl(6'h3, r1);
    fl(6'h2, 8'hff);
    bus(1'b0, 8'h4, 32'h1);
    bus(1'b0, 8'h0, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    lfsr = nxt(lfsr);
    unlock();
    xw(16'h3, lfsr[7:0], 1'b0);
    fl(6'h3, r1 & lfsr[7:0]);
    bus(1'b1, 8'h0, 32'h3);
    unlock();
    xw(16'h9, 8'h0, 1'b0);
    fl(6'h3, 8'hff);
    fl(6'hf, 8'hff);
    bus(1'b1, 8'h0, 32'h0);
    bus(1'b1, 8'h0, 32'h1);
    unlock();
    xw(16'h105, 8'h0, 1'b1);
    fl(6'h5, 8'hff);
    rst();
    bus(1'b1, 8'h0, 32'h2);
    q.push_back({16'h1234, 8'h0, 8'h77});
    xw(16'h1234, 8'h77, 1'b0);
    bus(1'b0, 8'h4, 32'h1);
    bus(1'b1, 8'h0, 32'h1);
    xw(16'h3, 8'h0, 1'b0);
    unlock();
    bus(1'b0, 8'h4, 32'h8);
    bus(1'b0, 8'h8, 32'h2);
    rst();
    bus(1'b1, 8'h4, 32'h11);
    bus(1'b0, 8'h4, 32'h8);
    rst();
    bus(1'b1, 8'h4, 32'hf1);
    bus(1'b0, 8'h4, 32'h8);
    rst();
    sup_rs <= 1'b0;
    bus(1'b1, 8'h0, 32'h1);
    unlock();
    q.push_back(32'h1);
    xw(16'h4, 8'h0, 1'b0);
    fl(6'h4, 8'hff);
    rst();
    bus(1'b0, 8'hc, 32'h1);
    bus(1'b1, 8'hc, 32'h1);
    bus(1'b0, 8'hc, 32'h0);
    summarize();
  end
endmodule

// file: rtl/fpec_consts.svh
// fpec_consts.svh: constants of the flash program/erase control block.
// assumes: included by its bare name from the top module only.
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses, one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define FPEC_OFS_CONTROL 4'h0
`define FPEC_OFS_KEY 4'h4
`define FPEC_OFS_STATUS 4'h8
`define FPEC_OFS_RESET_SOURCE_REGISTER 4'hc

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FPEC_BIT_SWE 0
`define FPEC_BIT_SEE 1
`define FPEC_BIT_BUSY 0
`define FPEC_BIT_BLOCKED 1
`define FPEC_BIT_OPEN 2
`define FPEC_BIT_FERR 0

// ----------------------------------------------------------------------
// key codes, flash values, address limits
// ----------------------------------------------------------------------
`define FPEC_KEY_FIRST 8'ha5
`define FPEC_KEY_SECOND 8'hf1
`define FPEC_ERASED_BYTE 8'hff
`define FPEC_SHORT_ADDR_MAX 16'h00ff
`define FPEC_PAGE_BYTES 1024
`define FPEC_NUM_PAGES 64

// ----------------------------------------------------------------------
// timing: times in ns, clock in MHz; cycle counts derived in the module
// ----------------------------------------------------------------------
`define FPEC_CLK_MHZ 40
`define FPEC_PROG_TIME_NS 1000
`define FPEC_ERASE_TIME_NS 30000

`endif

// file: rtl/fpec_pkg.sv
// fpec_pkg.sv: types of the flash program/erase control block.
// assumes: nothing is imported; users write fpec_pkg::name.
package fpec_pkg;

  // key unlock state, one-hot
  typedef enum logic [3:0] {
    KEY_LOCKED = 4'h1,
    KEY_HALF = 4'h2,
    KEY_OPEN = 4'h4,
    KEY_BLOCKED = 4'h8
  } fpec_key_t;

  // operation sequencer state, one-hot
  typedef enum logic [2:0] {
    OP_IDLE = 3'h1,
    OP_PROG = 3'h2,
    OP_ERASE = 3'h4
  } fpec_op_t;

endpackage

// file: rtl/fpec_top.sv
// fpec_top.sv: self-programming control of the on-chip program flash,
// holding the flash array, key lock, timed program/erase and cpu stall.
// assumes: one clock hclk, AHB-Lite single slave, cpu on the same clock,
// por_n only falls at power-on so the error flag survives system reset.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "fpec_consts.svh"

// How it works
// - byte write ANDs new data into old
// - 1024-byte pages; erase sets page to ff
// - program and erase timed by hardware
// - cpu stalled while operation runs
// - write enable routes external-move writes to flash
// - write enable stays set until software clears
// - supply monitor off forces flash error reset
// - bad key code blocks until reset
// - flash attempt while locked blocks until reset
// - key relocks after each operation
// - erase-enabled write erases whole addressed page
// - plain write programs exactly one byte
// - short-address writes above 00ff never touch flash
// - uninitialised device programs only via debug port
// - erase needs both enables; write needs one
// - flash error flag reads one after error reset
module fpec_top #(
  parameter int PAGE_BYTES = `FPEC_PAGE_BYTES,
  parameter int NUM_PAGES = `FPEC_NUM_PAGES,
  parameter int PROG_CYC =
    (`FPEC_PROG_TIME_NS * `FPEC_CLK_MHZ + 999) / 1000,
  parameter int ERASE_CYC =
    (`FPEC_ERASE_TIME_NS * `FPEC_CLK_MHZ + 999) / 1000,
  localparam int AW = $clog2(PAGE_BYTES * NUM_PAGES),
  localparam int PW = $clog2(PAGE_BYTES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic xw_valid,
  input wire logic [15:0] xw_addr,
  input wire logic [7:0] xw_data,
  input wire logic xw_short,
  output logic xram_we,
  output logic [15:0] xram_addr,
  output logic [7:0] xram_data,
  output logic cpu_stall,
  input wire logic [AW-1:0] fetch_addr,
  output logic [7:0] fetch_data,
  input wire logic supply_mon_en,
  input wire logic supply_mon_rst_src,
  input wire logic init_strap,
  input wire logic dbg_we,
  input wire logic dbg_erase,
  input wire logic [AW-1:0] dbg_addr,
  input wire logic [7:0] dbg_data,
  output logic flash_err_rst
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  // ce low freezes every flip-flop and the array; the bus stalls with it
  // through hreadyout, so no AHB transfer is lost while frozen; an external-move write to an idle frozen block is dropped
  fpec_pkg::fpec_key_t key_ff, nxt_key;
  fpec_pkg::fpec_op_t op_ff, nxt_op;
  logic store_write_enable_ff;
  logic store_erase_enable_ff;
  logic flash_error_flag_ff;
  logic [AW-1:0] op_addr_ff;
  logic [7:0] op_data_ff;
  logic [15:0] cnt_ff;
  logic [3:0] ph_addr_ff;
  logic ph_wr_ff;
  logic [31:0] hrdata_ff;
  logic xram_we_ff;
  logic [15:0] xram_addr_ff;
  logic [7:0] xram_data_ff;
  logic [7:0] fetch_data_ff;
  logic err_rst_ff;
  logic init_meta_ff;
  logic init_ff;
  logic [7:0] mem [0:PAGE_BYTES*NUM_PAGES-1];

  function automatic fpec_pkg::fpec_key_t key_step(
    input fpec_pkg::fpec_key_t cur,
    input logic [7:0] code
  );
    fpec_pkg::fpec_key_t res;
    case (cur)
      fpec_pkg::KEY_LOCKED: begin
        res = (code == `FPEC_KEY_FIRST) ? fpec_pkg::KEY_HALF
                                       : fpec_pkg::KEY_BLOCKED;
      end
      fpec_pkg::KEY_HALF: begin
        res = (code == `FPEC_KEY_SECOND) ? fpec_pkg::KEY_OPEN
                                        : fpec_pkg::KEY_BLOCKED;
      end
      default: res = fpec_pkg::KEY_BLOCKED;
    endcase
    return res;
  endfunction

  // only the lowest 16 bytes of the slot decode; the rest reads as zero
  function automatic logic in_map(input logic [31:0] a);
    return (a[31:4] == 28'h0);
  endfunction

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  wire bus_in_map = in_map(haddr);
  wire addr_ph = hsel & hready & htrans[1];
  wire ctl_wr = ph_wr_ff & (ph_addr_ff == `FPEC_OFS_CONTROL);
  wire key_wr = ph_wr_ff & (ph_addr_ff == `FPEC_OFS_KEY);
  wire rst_wr = ph_wr_ff & (ph_addr_ff == `FPEC_OFS_RESET_SOURCE_REGISTER);
  wire busy = (op_ff != fpec_pkg::OP_IDLE);
  wire [31:0] status_word = {29'h0, key_ff == fpec_pkg::KEY_OPEN,
    key_ff == fpec_pkg::KEY_BLOCKED, busy};
  wire [31:0] rd_word =
    (haddr[3:0] == `FPEC_OFS_CONTROL) ?
      {30'h0, store_erase_enable_ff, store_write_enable_ff} :
    (haddr[3:0] == `FPEC_OFS_KEY) ? {28'h0, key_ff} :
    (haddr[3:0] == `FPEC_OFS_STATUS) ? status_word :
    (haddr[3:0] == `FPEC_OFS_RESET_SOURCE_REGISTER) ? {31'h0, flash_error_flag_ff} :
    32'h0;
  // every read loads hrdata, so an unmapped read never shows stale data
  wire rd_hit = addr_ph & ~hwrite;

  // --------------------------------------------------------------------
  // external-move write steering
  // --------------------------------------------------------------------
  wire xw_fire = xw_valid & ~busy;
  wire short_bad = xw_short & (xw_addr > `FPEC_SHORT_ADDR_MAX);
  wire to_xram = xw_fire & ~store_write_enable_ff;
  // an uninitialised device drops software writes silently: they reach
  // neither flash nor data memory, and raise no error reset
  wire sw_try = xw_fire & store_write_enable_ff & init_ff
    & ~short_bad;
  wire sup_ok = supply_mon_en & supply_mon_rst_src;
  wire err_go = sw_try & ~sup_ok;
  wire key_open = (key_ff == fpec_pkg::KEY_OPEN);
  wire sw_go = sw_try & sup_ok & key_open;
  wire sw_lockout = sw_try & sup_ok & ~key_open;
  wire dbg_go = dbg_we & ~busy & ~xw_fire;
  wire start_erase = (sw_go & store_erase_enable_ff)
    | (dbg_go & dbg_erase);
  wire start_prog = (sw_go & ~store_erase_enable_ff)
    | (dbg_go & ~dbg_erase);
  wire [AW-1:0] start_addr = sw_go ? xw_addr[AW-1:0] : dbg_addr;
  wire [7:0] start_data = sw_go ? xw_data : dbg_data;
  wire [15:0] op_len = (op_ff == fpec_pkg::OP_ERASE) ?
    16'(ERASE_CYC) : 16'(PROG_CYC);
  wire op_done = busy & (cnt_ff == op_len - 16'h1);
  wire [AW-1:0] erase_addr =
    {op_addr_ff[AW-1:PW], cnt_ff[PW-1:0]};
  // the page is cleared one byte a cycle, so ERASE_CYC must not be
  // shorter than PAGE_BYTES or the top of the page stays programmed
  wire erase_step = (op_ff == fpec_pkg::OP_ERASE)
    & (cnt_ff < 16'(PAGE_BYTES));
  wire prog_step = (op_ff == fpec_pkg::OP_PROG) & op_done;

  // --------------------------------------------------------------------
  // sequencer and key lock
  // --------------------------------------------------------------------
  assign nxt_op = start_erase ? fpec_pkg::OP_ERASE :
    start_prog ? fpec_pkg::OP_PROG :
    op_done ? fpec_pkg::OP_IDLE : op_ff;
  // a key write racing a flash write loses: the write acts on the old key
  assign nxt_key =
    (sw_lockout | (key_ff == fpec_pkg::KEY_BLOCKED)) ?
      fpec_pkg::KEY_BLOCKED :
    (op_done & (key_ff == fpec_pkg::KEY_OPEN)) ?
      fpec_pkg::KEY_LOCKED :
    (key_wr & ~xw_fire & ~busy) ? key_step(key_ff, hwdata[7:0]) :
    key_ff;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_meta_ff <= 1'b0;
      init_ff <= 1'b0;
    end else if (ce) begin
      init_meta_ff <= init_strap;
      init_ff <= init_meta_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_ff <= 1'b0;
      ph_addr_ff <= 4'h0;
      hrdata_ff <= 32'h0;
    end else if (ce) begin
      ph_wr_ff <= addr_ph & hwrite & bus_in_map;
      ph_addr_ff <= haddr[3:0];
      if (rd_hit) begin
        hrdata_ff <= bus_in_map ? rd_word : 32'h0;
      end
    end
  end

  // enables only change on a software write, never by an operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_write_enable_ff <= 1'b0;
      store_erase_enable_ff <= 1'b0;
    end else if (ce && ctl_wr) begin
      store_write_enable_ff <= hwdata[`FPEC_BIT_SWE];
      store_erase_enable_ff <= hwdata[`FPEC_BIT_SEE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_ff <= fpec_pkg::KEY_LOCKED;
      op_ff <= fpec_pkg::OP_IDLE;
      op_addr_ff <= '0;
      op_data_ff <= 8'h0;
      cnt_ff <= 16'h0;
    end else if (ce) begin
      key_ff <= nxt_key;
      op_ff <= nxt_op;
      if (start_erase || start_prog) begin
        op_addr_ff <= start_addr;
        op_data_ff <= start_data;
        cnt_ff <= 16'h0;
      end else if (busy) begin
        cnt_ff <= cnt_ff + 16'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xram_we_ff <= 1'b0;
      xram_addr_ff <= 16'h0;
      xram_data_ff <= 8'h0;
      err_rst_ff <= 1'b0;
    end else if (ce) begin
      xram_we_ff <= to_xram;
      if (to_xram) begin
        xram_addr_ff <= xw_addr;
        xram_data_ff <= xw_data;
      end
      err_rst_ff <= err_go;
    end
  end

  // power-on domain so the cause outlives the error reset itself;
  // an error in the clearing cycle keeps the flag set
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      flash_error_flag_ff <= 1'b0;
    end else if (ce) begin
      if (err_go) begin
        flash_error_flag_ff <= 1'b1;
      end else if (rst_wr && hwdata[`FPEC_BIT_FERR]) begin
        flash_error_flag_ff <= 1'b0;
      end
    end
  end

  // flash array, not reset: contents are non-volatile
  always_ff @(posedge hclk) begin
    if (ce) begin
      if (erase_step) begin
        mem[erase_addr] <= `FPEC_ERASED_BYTE;
      end else if (prog_step) begin
        mem[op_addr_ff] <= mem[op_addr_ff] & op_data_ff;
      end
      fetch_data_ff <= mem[fetch_addr];
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // zero wait states while running; a frozen block holds the bus off
  // rather than drop a data phase it cannot register
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign xram_we = xram_we_ff;
  assign xram_addr = xram_addr_ff;
  assign xram_data = xram_data_ff;
  assign cpu_stall = busy;
  assign fetch_data = fetch_data_ff;
  assign flash_err_rst = err_rst_ff;

endmodule
